// File: oag_operand_address_generator.v
`timescale 1ns/10ps
`default_nettype none
`include "oag_defs.vh"
// What this block does
// - immediate mode passes the 8-bit literal as operand, no memory access
// - direct mode addresses 0x00 to 0xff from the operand field, flagging 0x00 as a fault
// - plain indirect uses the indirect pointer pair as the address
// - data pointer plus unsigned 0..255 offset forms the address
// - stack pointer plus unsigned 0..255 offset forms the address
// - indirect pointer high at 0x04, low at 0x05
// - stack pointer high at 0x06, low at 0x07
// - data pointer high at 0x0c, low at 0x0d
// - writing 0x09 changes the program counter low byte
// - flag register sits at direct address 0x0b
// - carry bit 0, nibble carry bit 1, zero bit 2
// - brownout bit 3, watchdog timeout bit 4
// - flag bits 7:5 hold the program page selection
// - jump and call carry a 13-bit program address field
// - direct, indirect and offset modes share one datapath
module oag_operand_address_generator #(
  parameter AW = 16,
  parameter JW = `OAG_JUMP_WIDTH
) (
  input wire clk, // core clock
  input wire sys_rst, // sync reset, high
  input wire [2:0] mode, // operand mode
  input wire [7:0] operandField, // literal or offset or address
  input wire [JW-1:0] jumpTargetField, // jump or call target
  input wire jumpTake, // load jump target
  input wire pcAdvance, // step program counter
  input wire regWrite, // low register write strobe
  input wire [7:0] regAddr, // low register address
  input wire [7:0] regWdata, // low register write data
  input wire flagsUpdate, // alu flag update strobe
  input wire [2:0] aluFlags, // zero, nibble, carry
  input wire brownoutEvent, // brownout detected
  input wire timeoutEvent, // watchdog timed out
  output reg [7:0] regRdata, // low register read data
  output reg regHit, // address maps here
  output reg [AW-1:0] operandAddr_q, // registered address
  output reg [7:0] literalValue_q, // registered literal
  output reg memAccess_q, // registered memory access
  output reg addrFault_q, // registered range fault
  output wire [JW-1:0] progCounter, // program counter
  output wire [2:0] pageSelect // page selection
);
  // =====================================================
  // pointer and flag registers
  reg [7:0] ipHigh_q, ipLow_q, spHigh_q, spLow_q, dpHigh_q, dpLow_q;
  reg [7:0] flags_q;
  reg [JW-1:0] pc_q;
  reg [7:0] flags_d;
  wire [AW-1:0] addrNext;
  wire memNext, faultNext;

  wire [AW-1:0] indirectPtr = {ipHigh_q, ipLow_q};
  wire [AW-1:0] dataPtr = {dpHigh_q, dpLow_q};
  wire [AW-1:0] stackPtr = {spHigh_q, spLow_q};

  assign progCounter = pc_q;
  assign pageSelect = flags_q[`OAG_FLAG_PAGE_HI:`OAG_FLAG_PAGE_LO];

  function isWrite;
    input [7:0] a;
    input [7:0] target;
    input we;
    begin
      isWrite = we && (a == target);
    end
  endfunction

  // =====================================================
  // flag register next value
  always @* begin
    flags_d = flags_q;
    if (isWrite(regAddr, `OAG_ADDR_FLAGS, regWrite)) begin
      flags_d = regWdata;
    end
    if (flagsUpdate) begin
      flags_d[`OAG_FLAG_CARRY] = aluFlags[0];
      flags_d[`OAG_FLAG_NIBBLE] = aluFlags[1];
      flags_d[`OAG_FLAG_ZERO] = aluFlags[2];
    end
    if (brownoutEvent) begin
      flags_d[`OAG_FLAG_BROWNOUT] = 1'b1;
    end
    if (timeoutEvent) begin
      flags_d[`OAG_FLAG_TIMEOUT] = 1'b1;
    end
  end

  // =====================================================
  // register writes
  always @(posedge clk) begin
    if (sys_rst) begin
      ipHigh_q <= `OAG_RESET_BYTE;
      ipLow_q <= `OAG_RESET_BYTE;
      spHigh_q <= `OAG_RESET_BYTE;
      spLow_q <= `OAG_RESET_BYTE;
      dpHigh_q <= `OAG_RESET_BYTE;
      dpLow_q <= `OAG_RESET_BYTE;
      flags_q <= `OAG_RESET_BYTE;
      pc_q <= {JW{1'b0}};
    end else begin
      if (isWrite(regAddr, `OAG_ADDR_IND_HI, regWrite)) begin
        ipHigh_q <= regWdata;
      end
      if (isWrite(regAddr, `OAG_ADDR_IND_LO, regWrite)) begin
        ipLow_q <= regWdata;
      end
      if (isWrite(regAddr, `OAG_ADDR_STK_HI, regWrite)) begin
        spHigh_q <= regWdata;
      end
      if (isWrite(regAddr, `OAG_ADDR_STK_LO, regWrite)) begin
        spLow_q <= regWdata;
      end
      if (isWrite(regAddr, `OAG_ADDR_DAT_HI, regWrite)) begin
        dpHigh_q <= regWdata;
      end
      if (isWrite(regAddr, `OAG_ADDR_DAT_LO, regWrite)) begin
        dpLow_q <= regWdata;
      end
      flags_q <= flags_d;
      // virtual pc low write
      // pc low write beats jump and advance, as software asked for it
      if (isWrite(regAddr, `OAG_ADDR_PC_LOW, regWrite)) begin
        pc_q <= {pc_q[JW-1:8], regWdata};
      end else if (jumpTake) begin
        pc_q <= jumpTargetField;
      end else if (pcAdvance) begin
        pc_q <= pc_q + {{(JW-1){1'b0}}, 1'b1};
      end
    end
  end

  // =====================================================
  // register reads
  always @* begin
    regHit = 1'b1;
    case (regAddr)
      `OAG_ADDR_IND_HI: regRdata = ipHigh_q;
      `OAG_ADDR_IND_LO: regRdata = ipLow_q;
      `OAG_ADDR_STK_HI: regRdata = spHigh_q;
      `OAG_ADDR_STK_LO: regRdata = spLow_q;
      `OAG_ADDR_PC_LOW: regRdata = pc_q[7:0];
      `OAG_ADDR_FLAGS: regRdata = flags_q;
      `OAG_ADDR_DAT_HI: regRdata = dpHigh_q;
      `OAG_ADDR_DAT_LO: regRdata = dpLow_q;
      default: begin
        regRdata = 8'h00;
        regHit = 1'b0;
      end
    endcase
  end

  // =====================================================
  // address generation
  // shared calculator
  oag_addr_calc #(
    .AW(AW)
  ) calc (
    .mode(mode),
    .operandField(operandField),
    .indirectPtr(indirectPtr),
    .dataPtr(dataPtr),
    .stackPtr(stackPtr),
    .operandAddr(addrNext),
    .needsMemory(memNext),
    .addrFault(faultNext)
  );

  // pointers are sampled before this cycle's write lands
  always @(posedge clk) begin
    if (sys_rst) begin
      operandAddr_q <= {AW{1'b0}};
      literalValue_q <= 8'h00;
      memAccess_q <= 1'b0;
      addrFault_q <= 1'b0;
    end else begin
      operandAddr_q <= addrNext;
      literalValue_q <= (mode == `OAG_MODE_IMM) ? operandField : 8'h00;
      memAccess_q <= memNext;
      addrFault_q <= faultNext;
    end
  end
endmodule
`default_nettype wire

// File: oag_defs.vh
`ifndef OAG_DEFS_VH
`define OAG_DEFS_VH
// =====================================================
// operand modes
`define OAG_MODE_IMM 3'h0
`define OAG_MODE_DIR 3'h1
`define OAG_MODE_IND 3'h2
`define OAG_MODE_DPO 3'h3
`define OAG_MODE_SPO 3'h4
// =====================================================
// low register map
`define OAG_ADDR_IND_HI 8'h04
`define OAG_ADDR_IND_LO 8'h05
`define OAG_ADDR_STK_HI 8'h06
`define OAG_ADDR_STK_LO 8'h07
`define OAG_ADDR_PC_LOW 8'h09
`define OAG_ADDR_FLAGS 8'h0b
`define OAG_ADDR_DAT_HI 8'h0c
`define OAG_ADDR_DAT_LO 8'h0d
`define OAG_DIRECT_MIN 8'h01
`define OAG_OFFSET_MIN 16'h0020
// =====================================================
// flag bits
`define OAG_FLAG_CARRY 0
`define OAG_FLAG_NIBBLE 1
`define OAG_FLAG_ZERO 2
`define OAG_FLAG_BROWNOUT 3
`define OAG_FLAG_TIMEOUT 4
`define OAG_FLAG_PAGE_LO 5
`define OAG_FLAG_PAGE_HI 7
`define OAG_RESET_BYTE 8'h00
`define OAG_JUMP_WIDTH 13
`endif

// File: oag_addr_calc.v
`timescale 1ns/10ps
`default_nettype none
`include "oag_defs.vh"
// =====================================================
// operand address calculator
module oag_addr_calc #(
  parameter AW = 16
) (
  input wire [2:0] mode, // operand mode
  input wire [7:0] operandField, // operand field
  input wire [AW-1:0] indirectPtr, // indirect pointer
  input wire [AW-1:0] dataPtr, // data pointer
  input wire [AW-1:0] stackPtr, // stack pointer
  output reg [AW-1:0] operandAddr, // computed address
  output reg needsMemory, // data memory access
  output reg addrFault // address out of range
);
  function [AW-1:0] addOffset;
    input [AW-1:0] base;
    input [7:0] off;
    begin
      addOffset = base + {{(AW-8){1'b0}}, off};
    end
  endfunction

  always @* begin
    operandAddr = {AW{1'b0}};
    needsMemory = 1'b0;
    addrFault = 1'b0;
    case (mode)
      `OAG_MODE_IMM: begin
        needsMemory = 1'b0;
      end
      `OAG_MODE_DIR: begin
        operandAddr = {{(AW-8){1'b0}}, operandField};
        needsMemory = 1'b1;
        addrFault = (operandField < `OAG_DIRECT_MIN);
      end
      `OAG_MODE_IND: begin
        operandAddr = indirectPtr;
        needsMemory = 1'b1;
      end
      `OAG_MODE_DPO: begin
        operandAddr = addOffset(dataPtr, operandField);
        needsMemory = 1'b1;
        addrFault = (addOffset(dataPtr, operandField) < `OAG_OFFSET_MIN);
      end
      `OAG_MODE_SPO: begin
        operandAddr = addOffset(stackPtr, operandField);
        needsMemory = 1'b1;
        addrFault = (addOffset(stackPtr, operandField) < `OAG_OFFSET_MIN);
      end
      default: begin
        addrFault = 1'b1;
      end
    endcase
  end
endmodule
`default_nettype wire

// File: oag_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// checker on the top ports
module oag_monitor #(parameter AW = 16, parameter JW = 13) (
  input wire logic clk, sys_rst, regWrite, jumpTake, // controls
  input wire logic [2:0] mode, // operand mode
  input wire logic [7:0] operandField, regAddr, regWdata, // stimulus
  input wire logic [JW-1:0] jumpTargetField, progCounter, // pc path
  input wire logic regHit, memAccess_q, addrFault_q, // flags out
  input wire logic [AW-1:0] operandAddr_q, // address out
  input wire logic [7:0] literalValue_q, // literal out
  input wire logic [2:0] pageSelect // page out
);
  logic [15:0] dpPtr_q, spPtr_q;
  wire [JW-9:0] pcHigh = progCounter[JW-1:8];
  wire [2:0] wdTop = regWdata[7:5];
  wire pclWr = regWrite && regAddr == 8'h09;
  // shadow pointers: pre-write value serves the same cycle's address
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dpPtr_q <= 16'h0000;
      spPtr_q <= 16'h0000;
    end else if (regWrite) begin
      case (regAddr)
        8'h06: spPtr_q[15:8] <= regWdata;
        8'h07: spPtr_q[7:0] <= regWdata;
        8'h0c: dpPtr_q[15:8] <= regWdata;
        8'h0d: dpPtr_q[7:0] <= regWdata;
        default: ;
      endcase
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_imm_literal: assert property (mode == 3'h0 |=>
    literalValue_q == $past(operandField) && !memAccess_q)
    else $error("literal not passed");
  a_direct_addr: assert property (mode == 3'h1 |=>
    operandAddr_q == {8'h00, $past(operandField)} && memAccess_q
    && addrFault_q == ($past(operandField) == 8'h00))
    else $error("direct address wrong");
  a_dp_offset: assert property (mode == 3'h3 |=>
    operandAddr_q == $past(dpPtr_q) + $past(operandField))
    else $error("data pointer sum wrong");
  a_sp_offset: assert property (mode == 3'h4 |=>
    operandAddr_q == $past(spPtr_q) + $past(operandField))
    else $error("stack pointer sum wrong");
  a_reg_hit: assert property (regHit == (regAddr inside
    {8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0b, 8'h0c, 8'h0d}))
    else $error("register decode wrong");
  a_pcl_write: assert property (pclWr |=>
    progCounter[7:0] == $past(regWdata) && $stable(pcHigh))
    else $error("pc low write wrong");
  a_page_write: assert property (
    regWrite && regAddr == 8'h0b |=> pageSelect == $past(wdTop))
    else $error("page select wrong");
  a_jump_load: assert property (jumpTake && !pclWr |=>
    progCounter == $past(jumpTargetField))
    else $error("jump target not loaded");
  a_bad_mode: assert property (mode > 3'h4 |=>
    addrFault_q && !memAccess_q)
    else $error("bad mode not faulted");
  cover property (mode == 3'h3 ##1 !addrFault_q);
  cover property (jumpTake);
  cover property (pclWr);
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin \
  badCount++; $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_top;
  logic clk = 0, sys_rst = 1, jumpTake = 0, pcAdvance = 0, regWrite = 0;
  logic flagsUpdate = 0, brownoutEvent = 0, timeoutEvent = 0;
  logic [2:0] mode = 0, aluFlags = 0, pageSelect;
  logic [7:0] operandField = 0, regAddr = 0, regWdata = 0;
  logic [7:0] regRdata, literalValue_q, ma [8];
  logic [12:0] jumpTargetField = 0, progCounter;
  logic [15:0] operandAddr_q;
  logic regHit, memAccess_q, addrFault_q;
  int badCount = 0, totalChecks = 0;
  always #4 clk = ~clk;
  oag_operand_address_generator dut (.clk, .sys_rst, .mode, .operandField,
    .jumpTargetField, .jumpTake, .pcAdvance, .regWrite, .regAddr,
    .regWdata, .flagsUpdate, .aluFlags, .brownoutEvent, .timeoutEvent,
    .regRdata, .regHit, .operandAddr_q, .literalValue_q, .memAccess_q,
    .addrFault_q, .progCounter, .pageSelect);
  // ==========================================
  // shared bus tasks
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk); regWrite = 1; regAddr = a; regWdata = d;
    @(negedge clk); regWrite = 0;
  endtask
  task automatic rchk(input logic [7:0] a, e, input logic h);
    @(negedge clk); regAddr = a; #1;
    `CHK("rdata", e, regRdata)
    `CHK("hit", h, regHit)
  endtask
  task automatic op(input logic [2:0] m, input logic [7:0] f,
      input logic [15:0] a, input logic acc, flt);
    @(negedge clk); mode = m; operandField = f;
    @(negedge clk);
    if (acc) `CHK("addr", a, operandAddr_q)
    `CHK("mem", acc, memAccess_q)
    `CHK("fault", flt, addrFault_q)
  endtask
  // ==========================================
  // scenarios
  task automatic t_map;
    ma = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0b, 8'h0c, 8'h0d};
    rchk(8'h04, 8'h00, 1'b1);
    for (int i = 0; i < 8; i++) wr(ma[i], 8'(8'h11 * (i + 1)));
    for (int i = 0; i < 8; i++) rchk(ma[i], 8'(8'h11 * (i + 1)), 1'b1);
    `CHK("page", 3'h3, pageSelect)
    wr(8'h08, 8'hff);
    rchk(8'h08, 8'h00, 1'b0);
  endtask
  task automatic t_modes;
    wr(8'h04, 8'h12); wr(8'h05, 8'h34); wr(8'h0c, 8'h12);
    wr(8'h0d, 8'hf0); wr(8'h06, 8'h00); wr(8'h07, 8'h10);
    op(3'h0, 8'hab, 16'h0000, 1'b0, 1'b0);
    `CHK("lit", 8'hab, literalValue_q)
    op(3'h1, 8'hff, 16'h00ff, 1'b1, 1'b0);
    op(3'h1, 8'h00, 16'h0000, 1'b1, 1'b1);
    op(3'h2, 8'h77, 16'h1234, 1'b1, 1'b0);
    op(3'h3, 8'hff, 16'h13ef, 1'b1, 1'b0);
    op(3'h4, 8'h10, 16'h0020, 1'b1, 1'b0);
    op(3'h4, 8'h0f, 16'h001f, 1'b1, 1'b1);
    op(3'h5, 8'h00, 16'h0000, 1'b0, 1'b1);
  endtask
  task automatic t_flags;
    wr(8'h0b, 8'h00);
    @(negedge clk); flagsUpdate = 1; aluFlags = 3'b101; brownoutEvent = 1;
    @(negedge clk); flagsUpdate = 0; brownoutEvent = 0;
    rchk(8'h0b, 8'h0d, 1'b1);
    @(negedge clk); timeoutEvent = 1;
    @(negedge clk); timeoutEvent = 0;
    rchk(8'h0b, 8'h1d, 1'b1);
    wr(8'h0b, 8'ha0);
    `CHK("page", 3'h5, pageSelect)
  endtask
  task automatic t_pc;
    @(negedge clk); jumpTake = 1; jumpTargetField = 13'h1abc;
    @(negedge clk); jumpTake = 0;
    `CHK("pc", 13'h1abc, progCounter)
    pcAdvance = 1;
    @(negedge clk); pcAdvance = 0;
    `CHK("pc", 13'h1abd, progCounter)
    wr(8'h09, 8'h00);
    `CHK("pc", 13'h1a00, progCounter)
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 0;
    t_map;
    t_modes;
    t_flags;
    t_pc;
    tally_and_finish;
  end
  // the run needs about 75 cycles, so 2500 cycles means a hang
  initial begin
    #20000;
    badCount++;
    tally_and_finish;
  end
endmodule
bind oag_operand_address_generator oag_monitor #(.AW(AW), .JW(JW)) mon (
  .clk, .sys_rst, .regWrite, .jumpTake, .mode, .operandField, .regAddr,
  .regWdata, .jumpTargetField, .progCounter, .regHit, .memAccess_q,
  .addrFault_q, .operandAddr_q, .literalValue_q, .pageSelect);
`default_nettype wire
